// ==== inc/vid_in_pkg.sv ====
package vid_in_pkg;

  // ------------------------------------------------------------
  // Operating modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    mode_pass,
    mode_video,
    mode_transport
  } op_mode_t;

  // ------------------------------------------------------------
  // Register map (AXI4-Lite byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ctrl_addr = 8'h00;
  localparam logic [7:0] status_addr = 8'h04;
  localparam logic [7:0] lock_cfg_addr = 8'h08;

  // Control register fields
  localparam int ctrl_h_cfg_bit = 0;
  localparam int ctrl_trs_ins_bit = 1;
  localparam logic [1:0] ctrl_reset = 2'h0;

  // Status register fields
  localparam int stat_lock_bit = 0;
  localparam int stat_mode_lsb = 1;
  localparam int stat_wide_bit = 3;

  // ------------------------------------------------------------
  // Timing and data constants
  // ------------------------------------------------------------
  localparam int lat_video = 21;
  localparam int lat_transport = 11;
  localparam int lat_max = 21;
  localparam int lock_lines_def = 4;
  localparam logic [9:0] trs_ones = 10'h3ff;
  localparam logic [9:0] trs_zeros = 10'h000;
  localparam logic [9:0] k28_sync = 10'h0bc;
  localparam int f_bit = 8;
  localparam int v_bit = 7;
  localparam int h_bit = 6;

endpackage

// ==== verilog/sync2.sv ====
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Asynchronous input and synchronised output
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ==== verilog/vid_in_front.sv ====
module vid_in_front #(
  parameter int LOCK_LINES = vid_in_pkg::lock_lines_def
) (
  // System clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Parallel video link
  input wire logic parallel_clock,
  input wire logic [9:0] low_data_bus,
  input wire logic [9:0] high_data_bus,
  input wire logic odd_even_in,
  input wire logic frame_blank_in,
  input wire logic line_blank_in,
  // Mode pins
  input wire logic video_mode_pin,
  input wire logic transport_mode_pin,
  input wire logic bus_width_select,
  input wire logic timing_source_select,
  input wire logic proc_features_enable,
  // Processed output stream
  output logic [9:0] out_luma,
  output logic [9:0] out_chroma,
  output logic out_valid,
  output logic lock_indicator,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ------------------------------------------------------------
  // Input synchronisation
  // ------------------------------------------------------------
  localparam int SW = 29;
  logic [SW-1:0] sync_s;
  logic pclk_s, pclk_prev_q, pclk_rise;
  logic [9:0] lo_s, hi_s;
  logic f_s, v_s, h_s, vm_s, tm_s, wide_s, emb_s, en_s;

  // Every link and mode pin crosses two flops; data and flags stay aligned with the clock
  sync2 #(.W(SW)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .async_in({parallel_clock, low_data_bus, high_data_bus, odd_even_in, frame_blank_in,
               line_blank_in, video_mode_pin, transport_mode_pin, bus_width_select,
               timing_source_select, proc_features_enable}),
    .sync_out(sync_s)
  );
  assign {pclk_s, lo_s, hi_s, f_s, v_s, h_s, vm_s, tm_s, wide_s, emb_s, en_s} = sync_s;

  // Rising edge of the parallel clock gives the sample enable
  always_ff @(posedge clk) begin
    if (!rstn) pclk_prev_q <= 1'b0;
    else pclk_prev_q <= pclk_s;
  end
  assign pclk_rise = pclk_s & ~pclk_prev_q;

  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  function automatic vid_in_pkg::op_mode_t decode_mode(input logic vm, input logic tm);
    if (vm && !tm) decode_mode = vid_in_pkg::mode_video;
    else if (!vm && tm) decode_mode = vid_in_pkg::mode_transport;
    else decode_mode = vid_in_pkg::mode_pass; // Both high treated as pass-through
  endfunction

  vid_in_pkg::op_mode_t mode;
  logic wide;
  assign mode = decode_mode(vm_s, tm_s);
  assign wide = wide_s && (mode != vid_in_pkg::mode_transport);

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [1:0] ctrl_q;
  logic [15:0] lock_cfg_q;
  logic aw_q, w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;

  // Address and data taken in either order; response after both
  always_ff @(posedge clk) begin
    if (!rstn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      ctrl_q <= vid_in_pkg::ctrl_reset;
      lock_cfg_q <= 16'(LOCK_LINES);
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (aw_q && w_q && !s_axi_bvalid) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        if (awaddr_q == vid_in_pkg::ctrl_addr) ctrl_q <= wdata_q[1:0];
        else if (awaddr_q == vid_in_pkg::lock_cfg_addr) lock_cfg_q <= wdata_q[15:0];
        else if (awaddr_q != vid_in_pkg::status_addr) s_axi_bresp <= 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        // Ready flops reopen only once the response is gone
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read channel answers one cycle after the address is taken
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
      s_axi_arready <= 1'b1;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_arready <= 1'b0;
      s_axi_rresp <= 2'h0;
      unique case (s_axi_araddr)
        vid_in_pkg::ctrl_addr: s_axi_rdata <= {30'h0, ctrl_q};
        vid_in_pkg::status_addr: s_axi_rdata <= {28'h0, wide, mode, lock_indicator};
        vid_in_pkg::lock_cfg_addr: s_axi_rdata <= {16'h0, lock_cfg_q};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Input capture and lane assignment
  // ------------------------------------------------------------
  logic [9:0] y_in, c_in;
  logic mux_phase_q;
  logic trs_det;

  // 10-bit multiplexed words alternate chroma then luma on the high half
  always_comb begin
    y_in = hi_s;
    c_in = 10'h000;
    if (mode == vid_in_pkg::mode_transport) begin
      y_in = {2'b00, hi_s[7:0]};
    end else if (wide) begin
      c_in = lo_s;
    end else if (!mux_phase_q) begin
      c_in = hi_s;
      y_in = 10'h000;
    end
  end

  // Mux phase realigns on each TRS first word
  always_ff @(posedge clk) begin
    if (!rstn) mux_phase_q <= 1'b0;
    else if (pclk_rise) mux_phase_q <= (hi_s == vid_in_pkg::trs_ones) ? 1'b1 : ~mux_phase_q;
  end

  // ------------------------------------------------------------
  // TRS detection and flywheel lock
  // ------------------------------------------------------------
  logic [1:0] pre_q;
  logic [9:0] xyz_word;
  logic [15:0] lock_cnt_q;
  logic emb_f_q, emb_v_q, emb_h_q;
  logic ext_h_prev_q;
  logic ref_ok;
  localparam logic [7:0] k28_low = vid_in_pkg::k28_sync[7:0];

  // Preamble 3ff 000 000 then XYZ word
  assign xyz_word = hi_s;
  assign trs_det = (pre_q == 2'h3);

  always_ff @(posedge clk) begin
    if (!rstn) pre_q <= 2'h0;
    else if (pclk_rise) begin
      if (hi_s == vid_in_pkg::trs_ones) pre_q <= 2'h1;
      else if (hi_s == vid_in_pkg::trs_zeros && pre_q != 2'h0 && pre_q != 2'h3)
        pre_q <= pre_q + 2'h1;
      else pre_q <= 2'h0;
    end
  end

  // Embedded timing from the XYZ word of each TRS
  always_ff @(posedge clk) begin
    if (!rstn) begin
      emb_f_q <= 1'b0;
      emb_v_q <= 1'b0;
      emb_h_q <= 1'b0;
    end else if (pclk_rise && trs_det) begin
      emb_f_q <= xyz_word[vid_in_pkg::f_bit];
      emb_v_q <= xyz_word[vid_in_pkg::v_bit];
      emb_h_q <= xyz_word[vid_in_pkg::h_bit];
    end
  end

  // Lock reference: K28 sync word in transport mode, else embedded TRS words or external H rising edges
  always_ff @(posedge clk) begin
    if (!rstn) ext_h_prev_q <= 1'b0;
    else if (pclk_rise) ext_h_prev_q <= h_s;
  end
  always_comb begin
    if (mode == vid_in_pkg::mode_transport) ref_ok = (hi_s[7:0] == k28_low);
    else if (emb_s) ref_ok = trs_det;
    else ref_ok = h_s && !ext_h_prev_q;
  end

  // Lock after enough references; lost on pass-through mode
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lock_cnt_q <= 16'h0;
      lock_indicator <= 1'b0;
    end else if (mode == vid_in_pkg::mode_pass) begin
      lock_cnt_q <= 16'h0;
      lock_indicator <= 1'b0;
    end else if (pclk_rise && ref_ok) begin
      if (lock_cnt_q < lock_cfg_q) lock_cnt_q <= lock_cnt_q + 16'h1;
      lock_indicator <= (lock_cnt_q + 16'h1 >= lock_cfg_q);
    end
  end

  // ------------------------------------------------------------
  // TRS timing bit insertion
  // ------------------------------------------------------------
  logic f_use, v_use, h_use, proc_on;
  logic [9:0] y_fix, c_fix;
  logic h_ext, rx_f, rx_v, rx_h;

  // Bits of the TRS now passing win over the stored copy: EAV and SAV differ in H
  assign rx_f = trs_det ? xyz_word[vid_in_pkg::f_bit] : emb_f_q;
  assign rx_v = trs_det ? xyz_word[vid_in_pkg::v_bit] : emb_v_q;
  assign rx_h = trs_det ? xyz_word[vid_in_pkg::h_bit] : emb_h_q;

  // Insertion needs the enable pin high and the per-feature insert bit clear, in video mode only
  assign proc_on = en_s && ctrl_q[vid_in_pkg::ctrl_trs_ins_bit] == 1'b0 &&
                   mode == vid_in_pkg::mode_video;
  // With config 1 H follows TRS blanking; with 0 H spans EAV and SAV too
  assign h_ext = ctrl_q[vid_in_pkg::ctrl_h_cfg_bit] ? (h_s & rx_h) : h_s;
  assign f_use = emb_s ? rx_f : f_s;
  assign v_use = emb_s ? rx_v : v_s;
  assign h_use = emb_s ? rx_h : h_ext;

  function automatic logic [9:0] set_xyz(input logic [9:0] w, input logic f, input logic v,
                                         input logic h);
    set_xyz = w;
    set_xyz[vid_in_pkg::f_bit] = f;
    set_xyz[vid_in_pkg::v_bit] = v;
    set_xyz[vid_in_pkg::h_bit] = h;
  endfunction

  // Rewrite F, V and H in the XYZ word of each TRS
  always_comb begin
    y_fix = y_in;
    c_fix = c_in;
    if (proc_on && trs_det) begin
      y_fix = set_xyz(y_in, f_use, v_use, h_use);
      c_fix = wide ? set_xyz(c_in, f_use, v_use, h_use) : c_in;
      if (!wide && mux_phase_q == 1'b0) c_fix = set_xyz(c_in, f_use, v_use, h_use);
    end
  end

  // ------------------------------------------------------------
  // Latency pipeline
  // ------------------------------------------------------------
  logic [9:0] y_pipe_q [vid_in_pkg::lat_max];
  logic [9:0] c_pipe_q [vid_in_pkg::lat_max];

  // Shift on each parallel clock; tap chosen by mode
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < vid_in_pkg::lat_max; i++) begin
        y_pipe_q[i] <= 10'h000;
        c_pipe_q[i] <= 10'h000;
      end
    end else if (pclk_rise) begin
      y_pipe_q[0] <= y_fix;
      c_pipe_q[0] <= c_fix;
      for (int i = 1; i < vid_in_pkg::lat_max; i++) begin
        y_pipe_q[i] <= y_pipe_q[i-1];
        c_pipe_q[i] <= c_pipe_q[i-1];
      end
    end
  end

  // Output register; the extra flop is counted in the tap
  always_ff @(posedge clk) begin
    if (!rstn) begin
      out_luma <= 10'h000;
      out_chroma <= 10'h000;
      out_valid <= 1'b0;
    end else begin
      out_valid <= pclk_rise;
      // Word moves only with its pulse, so it stands until the next one
      if (pclk_rise && mode == vid_in_pkg::mode_transport) begin
        out_luma <= y_pipe_q[vid_in_pkg::lat_transport-1];
        out_chroma <= 10'h000;
      end else if (pclk_rise) begin
        out_luma <= y_pipe_q[vid_in_pkg::lat_video-1];
        out_chroma <= c_pipe_q[vid_in_pkg::lat_video-1];
      end
    end
  end

endmodule

// ==== verification/vid_in_front_properties.sv ====
module vid_in_front_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Mode pins and stream
  input wire logic video_mode_pin,
  input wire logic transport_mode_pin,
  input wire logic [9:0] out_luma,
  input wire logic [9:0] out_chroma,
  input wire logic out_valid,
  input wire logic lock_indicator,
  // Register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------
  // Stream
  // ----------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // One pulse per link word, and a link word spans many system clocks
  a_pulse_single: assert property (out_valid |=> !out_valid [*8])
    else $error("out_valid pulses too close");
  a_word_holds: assert property (!out_valid |-> $stable(out_luma) && $stable(out_chroma))
    else $error("output word moved without a pulse");
  // Pins need a few clocks through the synchroniser before they count
  a_pass_unlocked: assert property
    ((!video_mode_pin && !transport_mode_pin) [*6] |-> !lock_indicator)
    else $error("lock high in pass mode");
  a_transport_chroma: assert property
    ((!video_mode_pin && transport_mode_pin) [*6] ##0 out_valid |-> out_chroma == 10'h000)
    else $error("chroma not empty in transport mode");

  // ----------
  // Register bus
  // ----------
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_bresp_soon: assert property
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_rdata_hold: assert property
    (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule

// ==== verification/video_source.sv ====
module video_source (
  // Link clock and words
  output logic parallel_clock,
  output logic [9:0] high_data_bus,
  output logic [9:0] low_data_bus,
  // Timing flags
  output logic odd_even_in,
  output logic frame_blank_in,
  output logic line_blank_in
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [22:0] words[$];

  // Flags travel with each word, so the bench keeps them steady per field
  task automatic push(input logic [22:0] w);
    words.push_back(w);
  endtask

  // ----------
  // Link clock and data
  // ----------
  // Clock stands still once the queue runs dry; rate is scaled for the bench
  initial begin
    parallel_clock = 1'b0;
    {odd_even_in, frame_blank_in, line_blank_in, high_data_bus, low_data_bus} = '0;
    forever begin
      if (words.size() == 0) begin
        #8;
      end else begin
        {odd_even_in, frame_blank_in, line_blank_in, high_data_bus, low_data_bus} =
          words.pop_front();
        #62.5 parallel_clock = 1'b1;
        #62.5 parallel_clock = 1'b0;
      end
    end
  end
endmodule

// ==== verification/test_vid_in_front.sv ====
module test_vid_in_front;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------
  // Signals
  // ----------
  typedef struct packed {
    logic chk;
    logic [9:0] l;
    logic [9:0] c;
  } exp_t;
  logic clk, rstn, parallel_clock, odd_even_in, frame_blank_in, line_blank_in;
  logic [9:0] low_data_bus, high_data_bus, out_luma, out_chroma;
  logic video_mode_pin, transport_mode_pin, bus_width_select, timing_source_select;
  logic proc_features_enable, out_valid, lock_indicator;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  exp_t exq[$];
  exp_t note;
  int fails, num_checks;

  vid_in_front #(.LOCK_LINES(1)) vid_in_front_i (.*);
  video_source video_source_i (.*);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------
  // Helpers
  // ----------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // A stuck handshake ends the run instead of hanging it
  task automatic bound(inout int n);
    n++;
    if (n > 3000) begin
      fails++;
      close_out();
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      bound(n);
    end while (s_axi_bvalid !== 1'b1);
    check(32'(s_axi_bresp), 32'(rsp));
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] want, input logic [31:0] m,
                        input logic [1:0] rsp);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      bound(n);
    end while (s_axi_rvalid !== 1'b1);
    check(s_axi_rdata & m, want & m);
    check(32'(s_axi_rresp), 32'(rsp));
  endtask

  // cfg is {video, transport, wide, embedded, enable, f, v, h}; lk 2 leaves lock unchecked
  // ctl is written to the control register right after reset when not zero
  task automatic run_row(input logic [7:0] cfg, input int lat, input int lk,
                         input logic [1:0] ctl);
    logic [9:0] hi, lo;
    logic [2:0] fvh;
    logic tm, ins;
    logic [1:0] md;
    int n;
    n = 0;
    tm = cfg[6] && !cfg[7];
    md = tm ? 2'h2 : (cfg[7] && !cfg[6]) ? 2'h1 : 2'h0;
    rstn <= 1'b0;
    {video_mode_pin, transport_mode_pin, bus_width_select, timing_source_select,
      proc_features_enable} <= cfg[7:3];
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    if (ctl != 2'h0) axi_wr(vid_in_pkg::ctrl_addr, 32'(ctl), 2'h0);
    // The first lat pulses show the cleared pipeline
    repeat (lat) exq.push_back('0);
    for (int i = 0; i < 16 + lat; i++) begin
      rnd = lfsr(rnd);
      hi = i == 0 ? (tm ? 10'h0bc : 10'h3ff) : i == 3 ? 10'h225 : 10'h000;
      if (i > 3) hi = {1'b0, rnd[8:0]};
      if (tm) hi[9:8] = 2'h0;
      lo = {1'b0, rnd[18:10]};
      // Embedded timing keeps the received bits; config 1 gates H by the received H bit
      fvh = cfg[4] ? hi[8:6] : {cfg[2:1], cfg[0] && (!ctl[0] || hi[6])};
      ins = md == 2'h1 && cfg[3] && !ctl[1] && i == 3;
      video_source_i.push({cfg[2:0], hi, lo});
      if (i < 16) begin
        if (tm) exq.push_back({1'b1, hi, 10'h000});
        else if (md == 2'h1 && !cfg[5])
          exq.push_back({1'b1, i[0] ? {hi, 10'h000} : {10'h000, hi}});
        else exq.push_back({1'b1, ins ? {hi[9], fvh, hi[5:0]} : hi,
                            ins ? {lo[9], fvh, lo[5:0]} : lo});
      end
    end
    while (exq.size() > 0) begin
      @(posedge clk);
      bound(n);
    end
    if (lk < 2) check(32'(lock_indicator), 32'(lk));
    axi_rd(vid_in_pkg::status_addr, {28'h0, cfg[5] && !tm, md, lk[0]},
           lk < 2 ? 32'hf : 32'he, 2'h0);
  endtask

  // ----------
  // Output watcher
  // ----------
  // Every pulse takes the oldest note; early pipeline words carry a note with chk clear
  always @(posedge clk) begin
    if (rstn === 1'b1 && out_valid === 1'b1) begin
      note = exq.size() > 0 ? exq.pop_front() : {1'b1, 20'hfffff};
      if (note.chk) begin
        check(32'(out_luma), 32'(note.l));
        check(32'(out_chroma), 32'(note.c));
      end
    end
  end

  // ----------
  // Main sequence
  // ----------
  initial begin
    rstn = 1'b0;
    {video_mode_pin, transport_mode_pin, bus_width_select, timing_source_select} = '0;
    proc_features_enable = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    rnd = 32'h68edce63;
    fails = 0;
    num_checks = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    axi_rd(vid_in_pkg::ctrl_addr, 32'h0, 32'hffffffff, 2'h0);
    axi_rd(vid_in_pkg::lock_cfg_addr, 32'h1, 32'hffffffff, 2'h0);
    axi_wr(vid_in_pkg::ctrl_addr, 32'h3, 2'h0);
    axi_rd(vid_in_pkg::ctrl_addr, 32'h3, 32'hffffffff, 2'h0);
    axi_wr(vid_in_pkg::status_addr, 32'hf, 2'h0);
    axi_rd(vid_in_pkg::status_addr, 32'h0, 32'hffffffff, 2'h0);
    axi_wr(8'h0c, 32'h1, 2'h2);
    axi_rd(8'h0c, 32'h0, 32'hffffffff, 2'h2);
    run_row(8'b10101101, 21, 2, 2'h0);
    run_row(8'b10101101, 21, 2, 2'h1);
    run_row(8'b10101111, 21, 2, 2'h2);
    run_row(8'b10100111, 21, 2, 2'h0);
    run_row(8'b10111111, 21, 1, 2'h0);
    run_row(8'b00101111, 21, 0, 2'h0);
    run_row(8'b01101111, 11, 1, 2'h0);
    run_row(8'b10000010, 21, 2, 2'h0);
    run_row(8'b11101111, 21, 0, 2'h0);
    close_out();
  end
endmodule

bind vid_in_front vid_in_front_properties props_i (.*);
